// *** rfsw_pkg.sv ***
`default_nettype none
package rfsw_pkg;
  // Clock figures
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam logic [5:0] CYC_PER_US = 6'(CLK_HZ / US_PER_S);
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CMD = 6'h04;
  localparam logic [5:0] OFS_START = 6'h08;
  localparam logic [5:0] OFS_STOP = 6'h0c;
  localparam logic [5:0] OFS_CENTER = 6'h10;
  localparam logic [5:0] OFS_SPAN = 6'h14;
  localparam logic [5:0] OFS_STEP_LIN = 6'h18;
  localparam logic [5:0] OFS_STEP_LOG = 6'h1c;
  localparam logic [5:0] OFS_DWELL = 6'h20;
  localparam logic [5:0] OFS_CURRENT = 6'h24;
  localparam logic [5:0] OFS_STATUS = 6'h28;
  // Control field positions
  localparam int CTRL_FREQ_EN = 0;
  localparam int CTRL_LEVEL_EN = 1;
  localparam int CTRL_LF_EN = 2;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_MODE_HI = 6;
  localparam int CTRL_LOG = 8;
  localparam int CTRL_TRI = 9;
  localparam int CTRL_NEG = 10;
  // Command field positions
  localparam int CMD_EXEC = 0;
  localparam int CMD_RESET = 1;
  // Log step is a fraction of the frequency in units of 2^-16
  localparam int LOG_FRAC_BITS = 16;
  // Reset values
  localparam logic [31:0] START_RST = 32'h05f5_e100;
  localparam logic [31:0] STOP_RST = 32'h1dcd_6500;
  localparam logic [31:0] STEP_LIN_RST = 32'h000f_4240;
  localparam logic [31:0] STEP_LOG_RST = 32'h0000_028f;
  localparam logic [31:0] DWELL_US_RST = 32'h0000_2710;
  // Sweep modes
  typedef enum logic [2:0] {
    RFSW_AUTO = 3'h0,
    RFSW_SINGLE = 3'h1,
    RFSW_MAN_STEP = 3'h2,
    RFSW_EXT_SINGLE = 3'h3,
    RFSW_EXT_STEP = 3'h4,
    RFSW_EXT_START_STOP = 3'h5
  } rfsw_mode_t;
  typedef enum logic {RFSW_IDLE, RFSW_RUN} rfsw_state_t;
endpackage
`default_nettype wire

// *** rfsw_step_if.sv ***
`default_nettype none
// Step request and result between sequencer and step calculator
interface rfsw_step_if;
  logic [31:0] cur;
  logic [31:0] start;
  logic [31:0] stop;
  logic [31:0] step_lin;
  logic [31:0] step_log;
  logic log_sel;
  logic down;
  logic [31:0] nxt;
  logic past_end;
  modport seq (output cur, start, stop, step_lin, step_log, log_sel, down,
               input nxt, past_end);
  modport calc (input cur, start, stop, step_lin, step_log, log_sel, down,
                output nxt, past_end);
endinterface
`default_nettype wire

// *** rfsw_step_calc.sv ***
`default_nettype none
module rfsw_step_calc
  import rfsw_pkg::*;
(
  rfsw_step_if.calc s
);
  logic [63:0] prod;
  logic [31:0] inc;
  logic [32:0] sum;

  // Increment from spacing choice, never below one
  always_comb
  begin
    prod = 64'(s.cur) * 64'(s.step_log);
    if (s.log_sel)
      inc = prod[LOG_FRAC_BITS +: 32];
    else
      inc = s.step_lin;
    if (inc == 32'h0)
      inc = 32'h1;
  end

  // Next position and range overrun
  always_comb
  begin
    if (s.down)
    begin
      sum = {1'b0, s.cur} - {1'b0, inc};
      s.past_end = sum[32] || (sum[31:0] < s.start);
    end
    else
    begin
      sum = {1'b0, s.cur} + {1'b0, inc};
      s.past_end = sum > {1'b0, s.stop};
    end
    s.nxt = sum[31:0];
  end
endmodule
`default_nettype wire

// *** rfsw_sweep.sv ***
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module rfsw_sweep
  import rfsw_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_instrument_trigger_input,
  output logic [31:0] o_freq,
  output logic o_sweep_running,
  output logic o_freq_sweep_on,
  output logic o_level_sweep_on,
  output logic o_lf_sweep_on
);
  rfsw_step_if si ();
  rfsw_mode_t mode_q;
  rfsw_mode_t new_mode;
  rfsw_state_t st_q;
  logic fen_q, len_q, lfen_q, log_q, tri_q, neg_q;
  logic [31:0] start_q, stop_q, steplin_q, steplog_q, dwell_q, freq_q;
  logic [31:0] center, span, rd_mux, wmask;
  logic [32:0] c_start, c_stop;
  logic down_q, restart_q, ack_q, trig_q;
  logic [1:0] phase_q;
  logic [37:0] cnt_q, dwell_cyc;
  logic [31:0] rdata_q;
  logic wr_go, ctrl_wr, mode_chg, exec_go, rst_go, man_go, trig_edge, tick;
  logic end_turn, cyc_end, one_shot;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction

  // Bus handshake: one wait cycle, then the request completes
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr_go = i_avs_write & ack_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
  end

  // Derived centre and span
  assign span = stop_q - start_q;
  assign center = 32'(({1'b0, start_q} + {1'b0, stop_q}) >> 1);
  assign wmask = merge(32'h0, i_avs_writedata, i_avs_byteenable);

  // Read data mux
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (i_avs_address)
      OFS_CTRL:
        rd_mux = {21'h0, neg_q, tri_q, log_q, 1'b0, mode_q, 1'b0,
                  lfen_q, len_q, fen_q};
      OFS_START: rd_mux = start_q;
      OFS_STOP: rd_mux = stop_q;
      OFS_CENTER: rd_mux = center;
      OFS_SPAN: rd_mux = span;
      OFS_STEP_LIN: rd_mux = steplin_q;
      OFS_STEP_LOG: rd_mux = steplog_q;
      OFS_DWELL: rd_mux = dwell_q;
      OFS_CURRENT: rd_mux = freq_q;
      OFS_STATUS:
        rd_mux = {27'h0, restart_q, phase_q, down_q, st_q == RFSW_RUN};
      default: rd_mux = 32'h0;
    endcase
  end

  // Registered read data, valid at the completing edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_q <= 32'h0;
    else if (i_avs_read & ~ack_q)
      rdata_q <= rd_mux;
  end
  assign o_avs_readdata = rdata_q;

  // Command decode
  assign ctrl_wr = wr_go && (i_avs_address == OFS_CTRL);
  assign new_mode = rfsw_mode_t'(wmask[CTRL_MODE_HI:CTRL_MODE_LO]);
  assign mode_chg = ctrl_wr && i_avs_byteenable[0] && (new_mode != mode_q) &&
                    (new_mode <= RFSW_EXT_START_STOP);
  assign exec_go = wr_go && (i_avs_address == OFS_CMD) && wmask[CMD_EXEC];
  assign rst_go = wr_go && (i_avs_address == OFS_CMD) && wmask[CMD_RESET];
  assign man_go = wr_go && (i_avs_address == OFS_CURRENT);

  // Sweep-type enables, at most one at a time
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fen_q <= 1'b0;
      len_q <= 1'b0;
      lfen_q <= 1'b0;
    end
    else if (ctrl_wr && i_avs_byteenable[0])
    begin
      fen_q <= wmask[CTRL_FREQ_EN];
      len_q <= wmask[CTRL_LEVEL_EN] & ~wmask[CTRL_FREQ_EN];
      lfen_q <= wmask[CTRL_LF_EN] & ~wmask[CTRL_FREQ_EN] &
                ~wmask[CTRL_LEVEL_EN];
    end
  end

  // Mode and option bits
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q <= RFSW_AUTO;
      log_q <= 1'b0;
      tri_q <= 1'b0;
      neg_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      if (i_avs_byteenable[0] && (new_mode <= RFSW_EXT_START_STOP))
        mode_q <= new_mode;
      if (i_avs_byteenable[1])
      begin
        log_q <= wmask[CTRL_LOG];
        tri_q <= wmask[CTRL_TRI];
        neg_q <= wmask[CTRL_NEG];
      end
    end
  end

  // Range writes with centre/span recomputation
  assign c_start = {1'b0, wmask} - {2'b0, span[31:1]};
  assign c_stop = {1'b0, wmask} + {2'b0, span[31:1]};

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      start_q <= START_RST;
      stop_q <= STOP_RST;
    end
    else if (wr_go)
    begin
      unique case (i_avs_address)
        OFS_START: start_q <= merge(start_q, i_avs_writedata,
                                    i_avs_byteenable);
        OFS_STOP: stop_q <= merge(stop_q, i_avs_writedata,
                                  i_avs_byteenable);
        OFS_CENTER:
        begin
          start_q <= c_start[31:0];
          stop_q <= c_stop[31:0];
        end
        OFS_SPAN:
        begin
          start_q <= center - {1'b0, wmask[31:1]};
          stop_q <= center + {1'b0, wmask[31:1]};
        end
        default: ;
      endcase
    end
  end

  // Step widths and dwell
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      steplin_q <= STEP_LIN_RST;
      steplog_q <= STEP_LOG_RST;
      dwell_q <= DWELL_US_RST;
    end
    else if (wr_go)
    begin
      unique case (i_avs_address)
        OFS_STEP_LIN: steplin_q <= merge(steplin_q, i_avs_writedata,
                                         i_avs_byteenable);
        OFS_STEP_LOG: steplog_q <= merge(steplog_q, i_avs_writedata,
                                         i_avs_byteenable);
        OFS_DWELL: dwell_q <= merge(dwell_q, i_avs_writedata,
                                    i_avs_byteenable);
        default: ;
      endcase
    end
  end

  // Trigger edge detect, polarity selectable
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      trig_q <= 1'b0;
    else
      trig_q <= i_instrument_trigger_input;
  end
  assign trig_edge = neg_q ? (trig_q & ~i_instrument_trigger_input)
                           : (~trig_q & i_instrument_trigger_input);

  // Step calculator hookup
  assign si.cur = freq_q;
  assign si.start = start_q;
  assign si.stop = stop_q;
  assign si.step_lin = steplin_q;
  assign si.step_log = steplog_q;
  assign si.log_sel = log_q;
  assign si.down = down_q;

  rfsw_step_calc u_calc (
    .s (si.calc)
  );

  // Range end handling shared by every step source
  assign end_turn = si.past_end && !down_q && tri_q;
  assign cyc_end = si.past_end && !end_turn;
  assign one_shot = (mode_q == RFSW_SINGLE) || (mode_q == RFSW_EXT_SINGLE);
  assign dwell_cyc = 38'(dwell_q) * 38'(CYC_PER_US);
  assign tick = (cnt_q + 38'h1) >= dwell_cyc;

  // Sweep sequencer
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= RFSW_IDLE;
      freq_q <= START_RST;
      down_q <= 1'b0;
      restart_q <= 1'b0;
      phase_q <= 2'h0;
      cnt_q <= 38'h0;
    end
    else if (!fen_q)
    begin
      st_q <= RFSW_IDLE;
      cnt_q <= 38'h0;
    end
    else if (rst_go)
    begin
      freq_q <= start_q;
      down_q <= 1'b0;
      cnt_q <= 38'h0;
      if (mode_q == RFSW_SINGLE)
        st_q <= RFSW_IDLE;
    end
    else if (mode_chg)
    begin
      cnt_q <= 38'h0;
      phase_q <= 2'h0;
      unique case (new_mode)
        RFSW_AUTO:
        begin
          st_q <= RFSW_RUN;
          restart_q <= 1'b0;
        end
        RFSW_MAN_STEP:
        begin
          st_q <= RFSW_IDLE;
          restart_q <= 1'b0;
        end
        default:
        begin
          st_q <= RFSW_IDLE;
          restart_q <= 1'b1;
        end
      endcase
    end
    else if (exec_go && (mode_q == RFSW_SINGLE))
    begin
      freq_q <= start_q;
      down_q <= 1'b0;
      st_q <= RFSW_RUN;
      restart_q <= 1'b0;
      cnt_q <= 38'h0;
    end
    else if (trig_edge && (mode_q == RFSW_EXT_SINGLE))
    begin
      if (st_q == RFSW_IDLE)
      begin
        freq_q <= start_q;
        down_q <= 1'b0;
        st_q <= RFSW_RUN;
        restart_q <= 1'b0;
        cnt_q <= 38'h0;
      end
    end
    else if (trig_edge && (mode_q == RFSW_EXT_START_STOP))
    begin
      cnt_q <= 38'h0;
      restart_q <= 1'b0;
      if (phase_q == 2'h1)
      begin
        st_q <= RFSW_IDLE;
        phase_q <= 2'h2;
      end
      else
      begin
        freq_q <= start_q;
        down_q <= 1'b0;
        st_q <= RFSW_RUN;
        phase_q <= 2'h1;
      end
    end
    else if ((trig_edge && (mode_q == RFSW_EXT_STEP)) ||
             (man_go && (mode_q == RFSW_MAN_STEP)))
    begin
      if (restart_q)
      begin
        freq_q <= start_q;
        down_q <= 1'b0;
        restart_q <= 1'b0;
      end
      else if (end_turn)
        down_q <= 1'b1;
      else if (cyc_end)
      begin
        freq_q <= start_q;
        down_q <= 1'b0;
      end
      else
        freq_q <= si.nxt;
    end
    else if (st_q == RFSW_RUN)
    begin
      if (!tick)
        cnt_q <= cnt_q + 38'h1;
      else
      begin
        cnt_q <= 38'h0;
        if (end_turn)
          down_q <= 1'b1;
        else if (cyc_end)
        begin
          freq_q <= start_q;
          down_q <= 1'b0;
          if (one_shot)
            st_q <= RFSW_IDLE;
        end
        else
          freq_q <= si.nxt;
      end
    end
  end

  // Status outputs
  assign o_freq = freq_q;
  assign o_sweep_running = st_q == RFSW_RUN;
  assign o_freq_sweep_on = fen_q;
  assign o_level_sweep_on = len_q;
  assign o_lf_sweep_on = lfen_q;
endmodule
`default_nettype wire

// *** rfsw_trig_src.sv ***
`default_nettype none
// Trigger source: one pulse per request, idle at the inactive level
module rfsw_trig_src
(
  input wire logic i_clk,
  input wire logic i_fire,
  input wire logic i_neg,
  input wire logic [3:0] i_hold,
  output logic o_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  // Pulse length counter, short or long
  always_ff @(posedge i_clk)
    if (i_fire)
      cnt_q <= i_hold;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  // Active level is the inverse of the idle level
  assign o_trig = i_neg ^ (cnt_q != 4'h0);
endmodule
`default_nettype wire

// *** rfsw_sweep_checker.sv ***
`default_nettype none
module rfsw_sweep_checker
  import rfsw_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_instrument_trigger_input,
  input wire logic [31:0] o_freq,
  input wire logic o_sweep_running,
  input wire logic o_freq_sweep_on,
  input wire logic o_level_sweep_on,
  input wire logic o_lf_sweep_on
);
  logic wr_done, edge_seen, idle, trg_q, neg_q;
  logic [2:0] mode_q;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Completed write, active trigger edge, idle sweep
  assign wr_done = i_avs_write && !o_avs_waitrequest;
  assign edge_seen = neg_q ? (trg_q && !i_instrument_trigger_input)
                           : (!trg_q && i_instrument_trigger_input);
  assign idle = o_freq_sweep_on && !o_sweep_running;
  // Shadow of mode, slope and last trigger sample
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q <= 3'h0;
      neg_q <= 1'b0;
      trg_q <= 1'b0;
    end
    else
    begin
      trg_q <= i_instrument_trigger_input;
      if (wr_done && i_avs_address == OFS_CTRL && i_avs_byteenable[0]
          && i_avs_writedata[6:4] < 3'h6)
        mode_q <= i_avs_writedata[6:4];
      if (wr_done && i_avs_address == OFS_CTRL && i_avs_byteenable[1])
        neg_q <= i_avs_writedata[CTRL_NEG];
    end
  end
  sequence s_ctrl_wr;
    wr_done && i_avs_address == OFS_CTRL && i_avs_byteenable[0];
  endsequence
  sequence s_cmd_wr;
    wr_done && i_avs_address == OFS_CMD && i_avs_byteenable[0];
  endsequence
  property p_one_type;
    $onehot0({o_freq_sweep_on, o_level_sweep_on, o_lf_sweep_on});
  endproperty
  property p_freq_wins;
    s_ctrl_wr ##0 i_avs_writedata[CTRL_FREQ_EN] |=>
      o_freq_sweep_on && !o_level_sweep_on && !o_lf_sweep_on;
  endproperty
  property p_exec_ignored;
    s_cmd_wr ##0 (i_avs_writedata[1:0] == 2'h1 && idle && mode_q inside
      {RFSW_MAN_STEP, RFSW_EXT_SINGLE, RFSW_EXT_STEP}) |=> !o_sweep_running;
  endproperty
  property p_entry_halt;
    s_ctrl_wr ##0 (i_avs_writedata[CTRL_FREQ_EN]
      && i_avs_writedata[6:4] != mode_q
      && i_avs_writedata[6:4] inside {3'h1, 3'h3, 3'h4})
      |=> !o_sweep_running;
  endproperty
  property p_man_hold;
    mode_q == RFSW_MAN_STEP && o_freq_sweep_on && !wr_done
      && !$past(wr_done) |=> $stable(o_freq);
  endproperty
  property p_ext_start;
    mode_q == RFSW_EXT_SINGLE && idle && edge_seen && !wr_done
      |=> o_sweep_running;
  endproperty
  property p_ss_freeze;
    mode_q == RFSW_EXT_START_STOP && o_freq_sweep_on && o_sweep_running
      && edge_seen && !wr_done |=> !o_sweep_running && $stable(o_freq);
  endproperty
  property p_reset_halt;
    s_cmd_wr ##0 (i_avs_writedata[CMD_RESET] && mode_q == RFSW_SINGLE
      && o_freq_sweep_on) |=> !o_sweep_running;
  endproperty
  property p_single_rest;
    (mode_q == RFSW_SINGLE || mode_q == RFSW_EXT_SINGLE) && idle
      && !edge_seen && !wr_done |=> !o_sweep_running;
  endproperty
  a_one_type: assert property (p_one_type)
    else $error("more than one sweep type on");
  a_freq_wins: assert property (p_freq_wins)
    else $error("freq sweep enable did not clear others");
  a_exec_ignored: assert property (p_exec_ignored)
    else $error("execute started a sweep outside single mode");
  a_entry_halt: assert property (p_entry_halt)
    else $error("sweep kept running after mode entry");
  a_man_hold: assert property (p_man_hold)
    else $error("manual step moved without a write");
  a_ext_start: assert property (p_ext_start)
    else $error("trigger edge did not start a cycle");
  a_ss_freeze: assert property (p_ss_freeze)
    else $error("second trigger did not freeze the sweep");
  a_reset_halt: assert property (p_reset_halt)
    else $error("reset did not halt single sweep");
  a_single_rest: assert property (p_single_rest)
    else $error("single sweep restarted on its own");
endmodule
bind rfsw_sweep rfsw_sweep_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_instrument_trigger_input(i_instrument_trigger_input),
  .o_freq(o_freq), .o_sweep_running(o_sweep_running),
  .o_freq_sweep_on(o_freq_sweep_on), .o_level_sweep_on(o_level_sweep_on),
  .o_lf_sweep_on(o_lf_sweep_on)
);
`default_nettype wire

// *** rfsw_sweep_tb.sv ***
`default_nettype none
module rfsw_sweep_tb
  import rfsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ST = 32'h0beb_c200;
  localparam logic [31:0] SP = 32'h02fa_f080;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic avr = 1'b0;
  logic avw = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic fire_r = 1'b0;
  logic tneg = 1'b0;
  logic [3:0] thold = 4'h1;
  logic wreq, trg, run, f_on, l_on, lf_on;
  logic [31:0] rdat, freq, q, f;
  int err_count = 0;
  int checks = 0;
  // System clock
  always #10 clk = ~clk;
  rfsw_sweep dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(adr),
    .i_avs_read(avr), .i_avs_write(avw), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_instrument_trigger_input(trg),
    .o_freq(freq), .o_sweep_running(run), .o_freq_sweep_on(f_on),
    .o_level_sweep_on(l_on), .o_lf_sweep_on(lf_on)
  );
  rfsw_trig_src u_trig (
    .i_clk(clk), .i_fire(fire_r), .i_neg(tneg), .i_hold(thold),
    .o_trig(trg)
  );
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    avw <= w;
    avr <= !w;
    n = 0;
    // Pre-edge values of waitrequest and read data at each rising edge
    @(posedge clk);
    while (wreq !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        err_count++;
        final_report();
      end
      @(posedge clk);
    end
    q = rdat;
    avw <= 1'b0;
    avr <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic fire();
    @(posedge clk);
    fire_r <= 1'b1;
    @(posedge clk);
    fire_r <= 1'b0;
    repeat (12) @(negedge clk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (run !== 1'b0)
    begin
      @(negedge clk);
      n++;
      if (n > 5000)
      begin
        err_count++;
        final_report();
      end
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(freq, START_RST);
    rd(OFS_CENTER, 32'h11e1_a300);
    rd(OFS_SPAN, 32'h17d7_8400);
    wr(OFS_SPAN, 32'h0beb_c200);
    rd(OFS_START, ST);
    rd(OFS_STOP, 32'h17d7_8400);
    rd(6'h2c, 32'h0);
    wr(OFS_STEP_LIN, SP);
    wr(OFS_DWELL, 32'h1);
    wr(OFS_CTRL, 32'h2);
    chk(32'(l_on), 32'h1);
    wr(OFS_CTRL, 32'h11);
    chk({29'h0, f_on, l_on, lf_on}, 32'h4);
    wr(OFS_CMD, 32'h2);
    chk(freq, ST);
    wr(OFS_CMD, 32'h1);
    chk(32'(run), 32'h1);
    repeat (120) @(negedge clk);
    chk(freq, ST + SP + SP);
    wr(OFS_CMD, 32'h2);
    chk(32'(run), 32'h0);
    chk(freq, ST);
    wr(OFS_CMD, 32'h1);
    wait_idle();
    chk(freq, ST);
    repeat (100) @(negedge clk);
    chk(32'(run), 32'h0);
    wr(OFS_CTRL, 32'h21);
    wr(OFS_CMD, 32'h1);
    chk(32'(run), 32'h0);
    wr(OFS_CURRENT, 32'h11e1_a300);
    chk(freq, ST + SP);
    wr(OFS_CTRL, 32'h121);
    f = ST + SP;
    wr(OFS_CURRENT, 32'h11e1_a300);
    chk(freq, f + 32'((64'(f) * 64'(STEP_LOG_RST)) >> LOG_FRAC_BITS));
    wr(OFS_CTRL, 32'h41);
    fire();
    chk(freq, ST);
    fire();
    chk(freq, ST + SP);
    wr(OFS_CTRL, 32'h51);
    fire();
    chk(32'(run), 32'h1);
    repeat (100) @(negedge clk);
    fire();
    f = freq;
    chk(32'(run), 32'h0);
    repeat (100) @(negedge clk);
    chk(freq, f);
    fire();
    chk(freq, ST);
    @(posedge clk);
    tneg <= 1'b1;
    thold <= 4'h8;
    wr(OFS_CTRL, 32'h431);
    chk(32'(run), 32'h0);
    fire();
    chk(32'(run), 32'h1);
    wait_idle();
    chk(freq, ST);
    wr(OFS_CTRL, 32'h401);
    repeat (60) @(negedge clk);
    chk(32'(run), 32'h1);
    chk(freq, ST + SP);
    wr(OFS_CTRL, 32'h461);
    rd(OFS_CTRL, 32'h401);
    chk(32'(run), 32'h1);
    final_report();
  end
endmodule
`default_nettype wire
